// ==== slpc_pkg.sv ====
package slpc_pkg;

   // ----------------------------------------------------------------
   // register addresses (byte-wide registers on the serial port)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_LANE_SCRAMBLE   = 12'h453;
   localparam logic [11:0] ADDR_FRAME_OCTETS    = 12'h454;
   localparam logic [11:0] ADDR_MULTIFRAME_LEN  = 12'h455;
   localparam logic [11:0] ADDR_CONVERTER_COUNT = 12'h456;
   localparam logic [11:0] ADDR_RESOLUTION      = 12'h457;
   localparam logic [11:0] ADDR_SUBCLASS_WIDTH  = 12'h458;
   localparam logic [11:0] ADDR_VERSION_SAMPLES = 12'h459;
   localparam logic [11:0] ADDR_DENSITY_CTRL    = 12'h45a;
   localparam logic [11:0] ADDR_DESKEW_MASK     = 12'h46c;
   localparam logic [11:0] ADDR_FRAME_DIRECT    = 12'h476;
   localparam logic [11:0] ADDR_LANE_ENABLE     = 12'h47d;
   localparam logic [11:0] ADDR_CFG_STATUS      = 12'h030;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SCRAMBLE_BIT   = 7;
   localparam int HD_BIT         = 7;
   localparam int COUNT_MSB      = 4;
   localparam int SUBCLASS_LSB   = 5;
   localparam int UNSUPP_BIT     = 3;

   // ----------------------------------------------------------------
   // reset values (all configuration clears to zero)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] RD_ZERO   = 8'h00;

   // supported lanes-minus-one codes (one, two, four and eight lanes)
   localparam logic [4:0] LM1_1 = 5'h00;
   localparam logic [4:0] LM1_2 = 5'h01;
   localparam logic [4:0] LM1_4 = 5'h03;
   localparam logic [4:0] LM1_8 = 5'h07;

   // decoded link parameters handed to the deframer
   typedef struct packed {
      logic       descramble_en;
      logic [4:0] lanes_m1;
      logic [7:0] octets_m1;
      logic [4:0] frames_m1;
      logic [7:0] conv_m1;
      logic [2:0] subclass;
      logic [4:0] samples_m1;
      logic       high_density;
      logic [7:0] deskew_mask;
      logic [7:0] octets_direct;
      logic [7:0] lane_enable;
   } slpc_link_cfg_t;

   // serial-port register access
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } slpc_reg_req_t;

endpackage

// ==== slpc_regs.sv ====
`timescale 1ns/100ps
// --------------------------------------------------------------------
// Notes on behaviour
// R1: bit 7 of lane/scramble register enables descrambling of received link.
// R2: low five bits of lane/scramble register hold lanes per link minus one.
// R3: octets-per-frame register holds frame length minus one.
// R4: low five bits of multiframe register hold frames per multiframe minus one.
// R5: converter-count register holds converters per link minus one.
// R6: software always writes control bits per sample as zero.
// R7: software always writes resolution field as 0x0f for 16 bits.
// R8: top three bits of subclass register select link subclass.
// R9: software writes bits-per-sample field as 0xf, sixteen bits.
// R10: software writes version field 0x1 for this link standard.
// R11: low five bits of version register hold samples per frame minus one.
// R12: bit 7 of density register selects high-density format.
// R13: software always writes control words per frame as zero.
// R14: each deskew mask bit requests deskew of its lane.
// R15: second octets register holds frame length itself, not minus one.
// R16: each lane enable bit enables capture on its lane.
// R17: two-lane four-octet mode: four converters, one sample, no HD.
// R18: four-lane one-octet mode: two converters, one sample, HD, 32 frames.
// R19: software sets deskew bits first, then enable bits.
// R20: in dual-link use the second link mirrors the first.
// R21: status bit rises on an unsupported lane/converter/octet/sample mix.
// --------------------------------------------------------------------
module slpc_regs (
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire slpc_pkg::slpc_reg_req_t req,
   output logic [7:0]                   rdata,
   output logic                         rvalid,
   output slpc_pkg::slpc_link_cfg_t     link_cfg,
   output logic                         cfg_unsupported
);

   // --------------------------------------------------------------------
   // register storage
   // --------------------------------------------------------------------
   logic [7:0] lane_scramble_cfg_q,    lane_scramble_cfg_d;
   logic [7:0] frame_octets_cfg_q,     frame_octets_cfg_d;
   logic [7:0] multiframe_len_cfg_q,   multiframe_len_cfg_d;
   logic [7:0] converter_count_cfg_q,  converter_count_cfg_d;
   logic [7:0] resolution_cfg_q,       resolution_cfg_d;
   logic [7:0] subclass_width_cfg_q,   subclass_width_cfg_d;
   logic [7:0] version_samples_cfg_q,  version_samples_cfg_d;
   logic [7:0] density_ctrlword_cfg_q, density_ctrlword_cfg_d;
   logic [7:0] lane_deskew_mask_q,     lane_deskew_mask_d;
   logic [7:0] frame_octets_direct_q,  frame_octets_direct_d;
   logic [7:0] lane_enable_mask_q,     lane_enable_mask_d;

   // --------------------------------------------------------------------
   // read port and decoded outputs
   // --------------------------------------------------------------------
   logic [7:0]                 rdata_q,    rdata_d;
   logic                       rvalid_q,   rvalid_d;
   logic                       unsupp_q,   unsupp_d;
   slpc_pkg::slpc_link_cfg_t   cfg_q,      cfg_d;

   // --------------------------------------------------------------------
   // mode check
   // --------------------------------------------------------------------
   // checks whether the lane, converter, octet and sample counts form a
   // combination the deframer can map; anything else is flagged.
   // all four inputs are the stored minus-one codes, so the table below
   // compares codes directly and needs no adders.
   // the multiframe length, density bit and fixed fields do not take part:
   // a wrong value there is a software fault that this flag cannot see.
   function automatic logic mode_supported(input logic [4:0] l_m1,
                                           input logic [7:0] m_m1,
                                           input logic [7:0] f_m1,
                                           input logic [4:0] s_m1);
      logic ok;
      ok = 1'b0;
      case (l_m1)
         // eight lanes: four converters, one or two octets
         slpc_pkg::LM1_8: begin
            ok = (m_m1 == 8'h03) &&
                 ((f_m1 == 8'h00 && s_m1 == 5'h00) ||
                  (f_m1 == 8'h01 && s_m1 == 5'h01));
         end
         // four lanes: four converters at two octets, or two converters
         // at one octet (one sample) or two octets (two samples)
         slpc_pkg::LM1_4: begin
            ok = (m_m1 == 8'h03 && f_m1 == 8'h01 && s_m1 == 5'h00) ||
                 (m_m1 == 8'h01 && f_m1 == 8'h00 && s_m1 == 5'h00) ||
                 (m_m1 == 8'h01 && f_m1 == 8'h01 && s_m1 == 5'h01);
         end
         // two lanes: four converters at four octets, two converters at
         // two octets, one converter at one octet; always one sample
         slpc_pkg::LM1_2: begin
            ok = (m_m1 == 8'h03 && f_m1 == 8'h03 && s_m1 == 5'h00) ||
                 (m_m1 == 8'h01 && f_m1 == 8'h01 && s_m1 == 5'h00) ||
                 (m_m1 == 8'h00 && f_m1 == 8'h00 && s_m1 == 5'h00);
         end
         // one lane: two converters at four octets or one converter at
         // two octets; always one sample
         slpc_pkg::LM1_1: begin
            ok = (s_m1 == 5'h00) &&
                 ((m_m1 == 8'h01 && f_m1 == 8'h03) ||
                  (m_m1 == 8'h00 && f_m1 == 8'h01));
         end
         // any other lane count is not mapped at all
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction

   // --------------------------------------------------------------------
   // register writes; every field is stored as written so readback is
   // exact, fixed fields are software's responsibility
   // --------------------------------------------------------------------
   // unmapped addresses fall through every branch and change nothing;
   // the status byte is read-only, so a write aimed at it is dropped too.
   // masking the fixed fields here would hide a software slip from the
   // readback, so nothing is forced; the trade is one more rule on the host.
   always_comb begin
      lane_scramble_cfg_d    = lane_scramble_cfg_q;
      frame_octets_cfg_d     = frame_octets_cfg_q;
      multiframe_len_cfg_d   = multiframe_len_cfg_q;
      converter_count_cfg_d  = converter_count_cfg_q;
      resolution_cfg_d       = resolution_cfg_q;
      subclass_width_cfg_d   = subclass_width_cfg_q;
      version_samples_cfg_d  = version_samples_cfg_q;
      density_ctrlword_cfg_d = density_ctrlword_cfg_q;
      lane_deskew_mask_d     = lane_deskew_mask_q;
      frame_octets_direct_d  = frame_octets_direct_q;
      lane_enable_mask_d     = lane_enable_mask_q;
      if (req.wr) begin
         if (req.addr == slpc_pkg::ADDR_LANE_SCRAMBLE) begin
            lane_scramble_cfg_d = req.wdata;
         end else if (req.addr == slpc_pkg::ADDR_FRAME_OCTETS) begin
            frame_octets_cfg_d = req.wdata;
         end else if (req.addr == slpc_pkg::ADDR_MULTIFRAME_LEN) begin
            multiframe_len_cfg_d = req.wdata;
         end else if (req.addr == slpc_pkg::ADDR_CONVERTER_COUNT) begin
            converter_count_cfg_d = req.wdata;
         end else if (req.addr == slpc_pkg::ADDR_RESOLUTION) begin
            resolution_cfg_d = req.wdata;         // R6 R7
         end else if (req.addr == slpc_pkg::ADDR_SUBCLASS_WIDTH) begin
            subclass_width_cfg_d = req.wdata;     // R9
         end else if (req.addr == slpc_pkg::ADDR_VERSION_SAMPLES) begin
            version_samples_cfg_d = req.wdata;    // R10
         end else if (req.addr == slpc_pkg::ADDR_DENSITY_CTRL) begin
            density_ctrlword_cfg_d = req.wdata;   // R13
         end else if (req.addr == slpc_pkg::ADDR_DESKEW_MASK) begin
            lane_deskew_mask_d = req.wdata;
         end else if (req.addr == slpc_pkg::ADDR_FRAME_DIRECT) begin
            frame_octets_direct_d = req.wdata;
         end else if (req.addr == slpc_pkg::ADDR_LANE_ENABLE) begin
            lane_enable_mask_d = req.wdata;
         end
      end
   end

   // storage for the eleven byte registers; no value is given for them
   // after reset, so all clear to zero, which is an unmapped mode and
   // leaves the status bit raised until a full mode is programmed
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lane_scramble_cfg_q    <= slpc_pkg::REG_RESET;
         frame_octets_cfg_q     <= slpc_pkg::REG_RESET;
         multiframe_len_cfg_q   <= slpc_pkg::REG_RESET;
         converter_count_cfg_q  <= slpc_pkg::REG_RESET;
         resolution_cfg_q       <= slpc_pkg::REG_RESET;
         subclass_width_cfg_q   <= slpc_pkg::REG_RESET;
         version_samples_cfg_q  <= slpc_pkg::REG_RESET;
         density_ctrlword_cfg_q <= slpc_pkg::REG_RESET;
         lane_deskew_mask_q     <= slpc_pkg::REG_RESET;
         frame_octets_direct_q  <= slpc_pkg::REG_RESET;
         lane_enable_mask_q     <= slpc_pkg::REG_RESET;
      end else begin
         lane_scramble_cfg_q    <= lane_scramble_cfg_d;
         frame_octets_cfg_q     <= frame_octets_cfg_d;
         multiframe_len_cfg_q   <= multiframe_len_cfg_d;
         converter_count_cfg_q  <= converter_count_cfg_d;
         resolution_cfg_q       <= resolution_cfg_d;
         subclass_width_cfg_q   <= subclass_width_cfg_d;
         version_samples_cfg_q  <= version_samples_cfg_d;
         density_ctrlword_cfg_q <= density_ctrlword_cfg_d;
         lane_deskew_mask_q     <= lane_deskew_mask_d;
         frame_octets_direct_q  <= frame_octets_direct_d;
         lane_enable_mask_q     <= lane_enable_mask_d;
      end
   end

   // --------------------------------------------------------------------
   // field decode, mode check and readback
   // --------------------------------------------------------------------
   // decode works from the _d values so the outputs track a write one
   // cycle later, same as the stored register itself.
   // decoding from the _q values instead would add a cycle of lag between
   // the stored byte and the deframer's view of it; the wider cone of logic
   // in front of cfg_q is cheap at this size.
   always_comb begin
      cfg_d.descramble_en = lane_scramble_cfg_d[slpc_pkg::SCRAMBLE_BIT];      // R1
      cfg_d.lanes_m1      = lane_scramble_cfg_d[slpc_pkg::COUNT_MSB:0];       // R2
      cfg_d.octets_m1     = frame_octets_cfg_d;                               // R3
      cfg_d.frames_m1     = multiframe_len_cfg_d[slpc_pkg::COUNT_MSB:0];      // R4
      cfg_d.conv_m1       = converter_count_cfg_d;                            // R5
      cfg_d.subclass      = subclass_width_cfg_d[7:slpc_pkg::SUBCLASS_LSB];   // R8
      cfg_d.samples_m1    = version_samples_cfg_d[slpc_pkg::COUNT_MSB:0];     // R11
      cfg_d.high_density  = density_ctrlword_cfg_d[slpc_pkg::HD_BIT];         // R12
      cfg_d.deskew_mask   = lane_deskew_mask_d;                               // R14
      cfg_d.octets_direct = frame_octets_direct_d;                            // R15
      cfg_d.lane_enable   = lane_enable_mask_d;                               // R16
      // flag the combination; tables for two- and four-lane modes included
      unsupp_d = !mode_supported(cfg_d.lanes_m1, cfg_d.conv_m1,
                                 cfg_d.octets_m1, cfg_d.samples_m1);          // R21 R17 R18
      // readback: a read in the same cycle as a write sees the old byte,
      // because it selects the _q values; unmapped reads return zero
      rvalid_d = req.rd;
      rdata_d  = slpc_pkg::RD_ZERO;
      if (req.rd) begin
         if (req.addr == slpc_pkg::ADDR_LANE_SCRAMBLE) begin
            rdata_d = lane_scramble_cfg_q;
         end else if (req.addr == slpc_pkg::ADDR_FRAME_OCTETS) begin
            rdata_d = frame_octets_cfg_q;
         end else if (req.addr == slpc_pkg::ADDR_MULTIFRAME_LEN) begin
            rdata_d = multiframe_len_cfg_q;
         end else if (req.addr == slpc_pkg::ADDR_CONVERTER_COUNT) begin
            rdata_d = converter_count_cfg_q;
         end else if (req.addr == slpc_pkg::ADDR_RESOLUTION) begin
            rdata_d = resolution_cfg_q;
         end else if (req.addr == slpc_pkg::ADDR_SUBCLASS_WIDTH) begin
            rdata_d = subclass_width_cfg_q;
         end else if (req.addr == slpc_pkg::ADDR_VERSION_SAMPLES) begin
            rdata_d = version_samples_cfg_q;
         end else if (req.addr == slpc_pkg::ADDR_DENSITY_CTRL) begin
            rdata_d = density_ctrlword_cfg_q;
         end else if (req.addr == slpc_pkg::ADDR_DESKEW_MASK) begin
            rdata_d = lane_deskew_mask_q;
         end else if (req.addr == slpc_pkg::ADDR_FRAME_DIRECT) begin
            rdata_d = frame_octets_direct_q;
         end else if (req.addr == slpc_pkg::ADDR_LANE_ENABLE) begin
            rdata_d = lane_enable_mask_q;
         end else if (req.addr == slpc_pkg::ADDR_CFG_STATUS) begin
            rdata_d = slpc_pkg::RD_ZERO;
            rdata_d[slpc_pkg::UNSUPP_BIT] = unsupp_q;                         // R21
         end
      end
   end

   // output flip-flops; every output of the block comes from here, so the
   // deframer never sees a glitch from the decode or the mode table
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q    <= '0;
         unsupp_q <= 1'b1;      // all-zero reset value is not a mapped mode
         rdata_q  <= slpc_pkg::RD_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         cfg_q    <= cfg_d;
         unsupp_q <= unsupp_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // --------------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------------
   // lane deskew/enable ordering is left to software; hardware applies
   // each mask as soon as it is written.
   // limitation: enabling a lane before its deskew bit is set is not
   // refused here; the deframer then captures an unaligned lane.
   // only one link is held: a second link, where used, is a copy of
   // these registers kept by the host, not by this block.
   assign link_cfg        = cfg_q;      // R19
   assign cfg_unsupported = unsupp_q;
   assign rdata           = rdata_q;
   assign rvalid          = rvalid_q;

endmodule

// ==== slpc_regs_chk.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// register port checker
// ----------------------------------------------------------------
module slpc_regs_chk (
   input wire logic                    mclk,
   input wire logic                    rst_n,
   input wire slpc_pkg::slpc_reg_req_t req,
   input wire logic [7:0]              rdata,
   input wire logic                    rvalid,
   input wire slpc_pkg::slpc_link_cfg_t link_cfg,
   input wire logic                    cfg_unsupported
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // write strobe aimed at one byte register
   function automatic logic hit(slpc_pkg::slpc_reg_req_t r, logic [11:0] a);
      return r.wr && (r.addr == a);
   endfunction

   chk_scramble_bit: assert property (hit(req, 12'h453) |=> link_cfg.descramble_en == $past(req.wdata[7]))
      else $error("descramble enable does not follow the write");
   chk_lane_count: assert property (hit(req, 12'h453) |=> link_cfg.lanes_m1 == $past(req.wdata[4:0]))
      else $error("lane count does not follow the write");
   chk_octets_m1: assert property (hit(req, 12'h454) |=> link_cfg.octets_m1 == $past(req.wdata))
      else $error("frame length field does not follow the write");
   chk_frames_m1: assert property (hit(req, 12'h455) |=> link_cfg.frames_m1 == $past(req.wdata[4:0]))
      else $error("multiframe length does not follow the write");
   chk_conv_m1: assert property (hit(req, 12'h456) |=> link_cfg.conv_m1 == $past(req.wdata))
      else $error("converter count does not follow the write");
   chk_subclass_sel: assert property (hit(req, 12'h458) |=> link_cfg.subclass == $past(req.wdata[7:5]))
      else $error("subclass does not follow the write");
   chk_samples_m1: assert property (hit(req, 12'h459) |=> link_cfg.samples_m1 == $past(req.wdata[4:0]))
      else $error("samples per frame does not follow the write");
   chk_high_density: assert property (hit(req, 12'h45a) |=> link_cfg.high_density == $past(req.wdata[7]))
      else $error("density flag does not follow the write");
   chk_deskew_mask: assert property (hit(req, 12'h46c) |=> link_cfg.deskew_mask == $past(req.wdata))
      else $error("deskew mask does not follow the write");
   chk_octets_direct: assert property (hit(req, 12'h476) |=> link_cfg.octets_direct == $past(req.wdata))
      else $error("direct frame length does not follow the write");
   chk_lane_enable: assert property (hit(req, 12'h47d) ##1 !req.wr [*2] |=> link_cfg.lane_enable == $past(req.wdata, 3))
      else $error("lane enable mask lost or changed");
   // status may only move when the configuration it judges moved
   chk_unsupp_cause: assert property ($changed(cfg_unsupported) |-> $changed(link_cfg))
      else $error("status changed with no configuration change");

   cover property (hit(req, 12'h47d));
   cover property (req.wr && req.rd);
   cover property ($fell(cfg_unsupported));
endmodule

// ==== slpc_sw_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// configuring host: mode tables for two- and four-lane links
// ----------------------------------------------------------------
module slpc_sw_model (
   input  wire logic [1:0]  mode,
   input  wire logic [3:0]  idx,
   input  wire logic        scr,
   input  wire logic        sub1,
   input  wire logic        k16,
   output logic      [11:0] addr,
   output logic      [7:0]  data
);
   // mode 0: 2 lanes 4 octets, 1: 4 lanes 1 octet, 2: 4 lanes 2 octets, 3: 2 lanes 2 octets
   localparam logic [7:0] LANE [4] = '{8'h01, 8'h03, 8'h03, 8'h01};
   localparam logic [7:0] FM1  [4] = '{8'h03, 8'h00, 8'h01, 8'h01};
   localparam logic [7:0] CONV [4] = '{8'h03, 8'h01, 8'h01, 8'h01};
   localparam logic [7:0] SMP  [4] = '{8'h20, 8'h20, 8'h21, 8'h20};
   localparam logic [7:0] DENS [4] = '{8'h00, 8'h80, 8'h00, 8'h00};
   localparam logic [7:0] MASK [4] = '{8'h03, 8'h0f, 8'h0f, 8'h03};
   localparam logic [7:0] FDIR [4] = '{8'h04, 8'h01, 8'h02, 8'h02};

   // entries come out in table order: deskew mask ahead of lane enable;
   // one link only, a second link would be sent this very table again
   always_comb begin
      addr = 12'h000;
      data = 8'h00;
      case (idx)
         4'h0: begin addr = 12'h453; data = {scr, LANE[mode][6:0]}; end
         4'h1: begin addr = 12'h454; data = FM1[mode]; end
         4'h2: begin addr = 12'h455; data = (k16 && mode != 2'd1) ? 8'h0f : 8'h1f; end
         4'h3: begin addr = 12'h456; data = CONV[mode]; end
         4'h4: begin addr = 12'h457; data = 8'h0f; end
         4'h5: begin addr = 12'h458; data = {2'b00, sub1, 5'h0f}; end
         4'h6: begin addr = 12'h459; data = SMP[mode]; end
         4'h7: begin addr = 12'h45a; data = DENS[mode]; end
         4'h8: begin addr = 12'h46c; data = MASK[mode]; end
         4'h9: begin addr = 12'h476; data = FDIR[mode]; end
         default: begin addr = 12'h47d; data = MASK[mode]; end
      endcase
   end
endmodule

// ==== serial_link_param_config_bench.sv ====
`timescale 1ns/100ps
module serial_link_param_config_bench;
   logic                     mclk, rst_n, rvalid, cfg_unsupported, scr, sub1, k16;
   logic [1:0]               mode;
   logic [3:0]               idx;
   logic [11:0]              sw_addr, a;
   logic [7:0]               sw_data, rdata;
   slpc_pkg::slpc_reg_req_t  req;
   slpc_pkg::slpc_link_cfg_t link_cfg;
   logic [7:0]               mem [int];
   int                       fails, tests_run, seed;
   int                       regs [11] = '{'h453, 'h454, 'h455, 'h456, 'h457, 'h458, 'h459,
                                           'h45a, 'h46c, 'h476, 'h47d};
   logic [31:0]              combos [10] = '{32'h07030000, 32'h07030101, 32'h03030100,
      32'h03010000, 32'h03010101, 32'h01030300, 32'h01010100, 32'h01000000, 32'h00010300, 32'h00000100};

   slpc_regs u_dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
                    .link_cfg(link_cfg), .cfg_unsupported(cfg_unsupported));
   slpc_sw_model u_sw (.mode(mode), .idx(idx), .scr(scr), .sub1(sub1), .k16(k16),
                       .addr(sw_addr), .data(sw_data));

   initial mclk = 1'b0;
   always #2 mclk = ~mclk;

   // ----------------------------------------------------------------
   // reference model and port tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // the status is worked out from the model, never from the design
   function automatic logic supported();
      logic [31:0] k;
      k = {3'b0, mem['h453][4:0], mem['h456], mem['h454], 3'b0, mem['h459][4:0]};
      foreach (combos[i]) if (combos[i] == k) return 1'b1;
      return 1'b0;
   endfunction

   function automatic slpc_pkg::slpc_link_cfg_t exp_cfg();
      return {mem['h453][7], mem['h453][4:0], mem['h454], mem['h455][4:0], mem['h456],
              mem['h458][7:5], mem['h459][4:0], mem['h45a][7], mem['h46c], mem['h476], mem['h47d]};
   endfunction

   task automatic clear_model();
      foreach (regs[i]) mem[regs[i]] = 8'h00;
   endtask

   // one-cycle strobe; a read issued with it must still see the old value
   task automatic access(input logic [11:0] ad, input logic [7:0] d, input logic w, input logic r);
      logic [7:0] old;
      old = mem.exists(ad) ? mem[ad] : (ad == 12'h030 ? {4'h0, !supported(), 3'h0} : 8'h00);
      @(negedge mclk);
      req <= '{wr: w, rd: r, addr: ad, wdata: d};
      @(negedge mclk);
      req <= '0;
      if (w && mem.exists(ad)) mem[ad] = d;
      if (r) begin
         check(rvalid, 1'b1);
         check(rdata, old);
      end
   endtask

   task automatic verify();
      check(link_cfg, exp_cfg());
      check(cfg_unsupported, !supported());
      foreach (regs[i]) access(regs[i][11:0], 8'h00, 1'b0, 1'b1);
      access(12'h030, 8'h00, 1'b0, 1'b1);
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      req = '0;
      rst_n = 1'b0;
      {mode, idx, scr, sub1, k16} = '0;
      fails = 0;
      tests_run = 0;
      seed = $urandom(32'h66de);
      clear_model();
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      verify();
      // every mode table, with random scramble, subclass and multiframe picks
      for (int m = 0; m < 4; m++) begin
         {scr, sub1, k16} = 3'($urandom);
         mode = 2'(m);
         for (int i = 0; i < 11; i++) begin
            idx = 4'(i);
            #1;
            access(sw_addr, sw_data, 1'b1, 1'b0);
         end
         verify();
      end
      // random traffic, status and unmapped places included, some reads alongside writes
      repeat (40) begin
         case ($urandom % 4)
            0: a = 12'h030;
            1: a = 12'($urandom);
            default: a = regs[$urandom % 11][11:0];
         endcase
         access(a, 8'($urandom), 1'b1, 1'($urandom));
         verify();
      end
      // reset in mid-run clears everything again
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      clear_model();
      verify();
      summarize();
   end

   // the whole run is about 1300 cycles; this bound is far beyond it
   initial begin
      #200000;
      fails++;
      summarize();
   end
endmodule

bind slpc_regs slpc_regs_chk u_chk (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
   .rvalid(rvalid), .link_cfg(link_cfg), .cfg_unsupported(cfg_unsupported));
